// ==== isw_defs.svh ====
// register offsets, field positions, reset values and counts
// assumes inclusion by bare name from the main block and the bench
`ifndef ISW_DEFS_SVH
`define ISW_DEFS_SVH
// ====================
// register offsets (9-bit file address)
`define ISW_ADDR_TIMER0 9'h001
`define ISW_ADDR_STATUS 9'h003
`define ISW_ADDR_IRQCTL 9'h00B
`define ISW_ADDR_OPTION 9'h081
`define ISW_ADDR_OPTION_HI 9'h181
// ====================
// interrupt control fields
`define ISW_IRQ_PORT_CHG_FLAG 0
`define ISW_IRQ_EXT_FLAG 1
`define ISW_IRQ_T0_FLAG 2
`define ISW_IRQ_PORT_CHG_EN 3
`define ISW_IRQ_EXT_EN 4
`define ISW_IRQ_T0_EN 5
`define ISW_IRQ_PERIPH_EN 6
`define ISW_IRQ_GLOBAL_EN 7
// ====================
// option fields
`define ISW_OPT_RATIO_LSB 0
`define ISW_OPT_ASSIGN 3
`define ISW_OPT_T0_EDGE 4
`define ISW_OPT_T0_SRC 5
`define ISW_OPT_EXT_EDGE 6
// ====================
// status and config fields
`define ISW_STAT_PD 3
`define ISW_STAT_TO 4
`define ISW_CFG_WDT_EN 2
// ====================
// reset values and constants
`define ISW_RST_OPTION 8'hFF
`define ISW_RST_IRQCTL 8'h00
`define ISW_RST_TIMER0 8'h00
`define ISW_IRQ_VECTOR 13'h0004
`define ISW_WDT_BASE_TICKS 256
`endif

// ==== isw_irq_sleep_wdt.sv ====
// interrupt, sleep and watchdog control for a small core
// assumes one instruction clock, pins arriving asynchronously
//
// Overview of operation
// R1: ext pin edge per select sets flag
// R2: ext pin wakes only if enabled
// R3: timer wrap FF to 00 sets flag
// R4: upper port pin change sets flag
// R5: interrupt entry saves only return address
// R6: watchdog counts own oscillator, also asleep
// R7: awake time-out gives watchdog device reset
// R8: asleep time-out wakes, execution continues
// R9: any time-out clears time-out flag
// R10: config bit clear disables watchdog forever
// R11: one scaler shared, chosen by assign bit
// R12: clear or sleep resets watchdog and scaler (the scaler only when it is assigned to the watchdog)
// R13: clear zeroes scaler, keeps assignment
// R14: sleep clears watchdog, pd, sets to
// R15: pins hold drive state while asleep
// R16: reset pin resets, others wake
// R17: pd set at power-up, cleared by sleep
// R18: only listed peripherals may wake
// R19: wake needs source enable, not global
// R20: wake runs next instruction, then vectors
// R21: prefetched instruction runs first on wake
// R22: flags set regardless of enables
// R23: taking interrupt clears global, pushes, vectors
// R24: return pops and sets global enable
// R25: flags sticky; request when flag and enables
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "isw_defs.svh"
module isw_irq_sleep_wdt
  import isw_pkg::*;
#(
  parameter int WDT_BASE_TICKS = `ISW_WDT_BASE_TICKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] config_word,
  input wire logic wdt_osc_in,
  input wire logic timer_zero_pin,
  input wire logic [7:0] second_port_in,
  input wire logic [7:0] port_drive_d,
  input wire logic [7:0] port_oe_d,
  output logic [7:0] second_port_out,
  output logic [7:0] second_port_oe,
  input wire logic periph_irq_req,
  input wire logic periph_wake_req,
  input wire logic sleep_instr,
  input wire logic watchdog_clear_instr,
  input wire logic return_from_irq_instr,
  input wire logic instr_boundary,
  input wire logic [12:0] core_pc,
  output logic osc_driver_off,
  output logic device_reset,
  output logic stack_push,
  output logic [12:0] stack_push_data,
  output logic stack_pop,
  output logic pc_load,
  output logic [12:0] pc_load_addr
);
  // ====================
  // elaboration checks
  if (WDT_BASE_TICKS < 2 || WDT_BASE_TICKS > 65536) begin : g_chk
    $error("WDT_BASE_TICKS out of range");
  end

  localparam logic [15:0] BASE_LAST = 16'(WDT_BASE_TICKS - 1);

  // ====================
  // pin synchronisers
  logic [17:0] sync_a; // first stage, read only by sync_b
  logic [17:0] sync_b; // second stage
  logic [17:0] sync_c; // previous synced value for edges

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_a <= 18'h00000;
      sync_b <= 18'h00000;
      sync_c <= 18'h00000;
    end else begin
      sync_a <= {config_word, wdt_osc_in, timer_zero_pin, second_port_in};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  logic [7:0] cfg_s; // synced config word
  logic [7:0] port_s; // synced port inputs
  logic [7:0] port_d; // port inputs one cycle older
  assign cfg_s = sync_b[17:10];
  assign port_s = sync_b[7:0];
  assign port_d = sync_c[7:0];

  // ====================
  // registers and state
  isw_state_e state; // run or asleep
  isw_state_e next_state; // next run state
  isw_byte_t option; // timer and scaler config
  isw_byte_t irqctl; // interrupt flags and enables
  isw_byte_t timer0; // timer zero counter
  logic to_n; // time-out flag, low active
  logic pd_n; // power-down flag, low active
  logic [15:0] wdt_base; // watchdog base counter
  logic scaler_tick; // scaler output pulse

  logic run; // core is awake
  logic wdt_en; // watchdog enabled by config
  logic assign_wdt; // scaler belongs to watchdog
  logic osc_rise; // watchdog oscillator edge
  logic base_wrap; // base counter period end
  logic t0_raw; // undivided timer source pulse
  logic t0_inc; // timer increment
  logic t0_wr; // bus writes timer
  logic t0_ovf; // timer wraps
  logic wdt_timeout; // watchdog period over
  logic wdt_rst; // time-out while awake
  logic ext_evt; // valid ext pin edge
  logic port_evt; // upper port change
  logic irq_pend; // enabled interrupt waiting
  logic wake_req; // enabled wake source set
  logic sleep_taken; // sleep really entered
  logic wdt_clr_evt; // watchdog cleared by core
  logic take_irq; // interrupt vectored now
  logic return_from_irq_instr_evt; // return from interrupt
  logic scaler_clr; // scaler count cleared
  logic irq_wr; // bus writes irqctl
  logic opt_wr; // bus writes option

  assign run = (state == isw_st_run);
  assign wdt_en = cfg_s[`ISW_CFG_WDT_EN]; // [R10]
  assign assign_wdt = option[`ISW_OPT_ASSIGN]; // [R11]
  assign irq_wr = reg_wr && (reg_addr == `ISW_ADDR_IRQCTL);
  assign opt_wr = reg_wr && (reg_addr == `ISW_ADDR_OPTION || reg_addr == `ISW_ADDR_OPTION_HI);
  assign t0_wr = reg_wr && (reg_addr == `ISW_ADDR_TIMER0);

  // ====================
  // event decode
  // ext pin is bit 0 of the port; edge polarity from option
  assign ext_evt = option[`ISW_OPT_EXT_EDGE] ? (port_s[0] && !port_d[0]) : (!port_s[0] && port_d[0]); // [R1]
  assign port_evt = (port_s[7:4] != port_d[7:4]); // [R4]
  // request needs flag and enable; peripherals need their enable too
  assign irq_pend = (irqctl[`ISW_IRQ_EXT_FLAG] && irqctl[`ISW_IRQ_EXT_EN]) ||
                    (irqctl[`ISW_IRQ_T0_FLAG] && irqctl[`ISW_IRQ_T0_EN]) ||
                    (irqctl[`ISW_IRQ_PORT_CHG_FLAG] && irqctl[`ISW_IRQ_PORT_CHG_EN]) ||
                    (irqctl[`ISW_IRQ_PERIPH_EN] && periph_irq_req); // [R25]
  // wake ignores the global enable and the timer zero flag
  assign wake_req = (irqctl[`ISW_IRQ_EXT_FLAG] && irqctl[`ISW_IRQ_EXT_EN]) || // [R2]
                    (irqctl[`ISW_IRQ_PORT_CHG_FLAG] && irqctl[`ISW_IRQ_PORT_CHG_EN]) ||
                    (irqctl[`ISW_IRQ_PERIPH_EN] && periph_wake_req); // [R18] [R19]
  // sleep with a wake source already set completes as a no-op
  assign sleep_taken = sleep_instr && run && !wake_req;
  assign wdt_clr_evt = run && (watchdog_clear_instr || sleep_taken); // [R12]
  // never vector on the sleep itself: the prefetched one runs first
  assign take_irq = instr_boundary && run && !sleep_instr && !wdt_rst &&
                    irqctl[`ISW_IRQ_GLOBAL_EN] && irq_pend; // [R20] [R21]
  assign return_from_irq_instr_evt = return_from_irq_instr && run;

  // ====================
  // watchdog base count on its own oscillator
  assign osc_rise = sync_b[9] && !sync_c[9];
  assign base_wrap = wdt_en && osc_rise && (wdt_base == BASE_LAST);

  // base counter keeps running asleep, cleared by the core
  always_ff @(posedge clk) begin
    if (!rstn || !wdt_en || wdt_clr_evt) begin
      wdt_base <= 16'h0000;
    end else if (osc_rise) begin
      // [R6]
      wdt_base <= base_wrap ? 16'h0000 : wdt_base + 16'h0001;
    end
  end

  // ====================
  // shared scaler
  assign t0_raw = option[`ISW_OPT_T0_SRC] ?
                  (option[`ISW_OPT_T0_EDGE] ? (!sync_b[8] && sync_c[8]) : (sync_b[8] && !sync_c[8])) :
                  run;
  // clear keeps the assignment bit, only the count drops
  // a watchdog reset also drops it, so a stale timer tick is not seen as a second time-out
  assign scaler_clr = (assign_wdt && wdt_clr_evt) || (!assign_wdt && t0_wr) || wdt_rst ||
                      (opt_wr && (reg_wdata[`ISW_OPT_ASSIGN] != assign_wdt)); // [R13]

  isw_scaler u_scaler (
    .clk(clk),
    .rstn(rstn),
    .tick_in(assign_wdt ? base_wrap : t0_raw),
    .clear(scaler_clr),
    .assign_wdt(assign_wdt),
    .ratio(option[`ISW_OPT_RATIO_LSB +: 3]),
    .tick_out(scaler_tick)
  );

  assign t0_inc = assign_wdt ? t0_raw : scaler_tick; // [R11]
  assign wdt_timeout = wdt_en && !wdt_clr_evt && (assign_wdt ? scaler_tick : base_wrap); // [R10]
  assign wdt_rst = wdt_timeout && run; // [R7]
  assign t0_ovf = t0_inc && !t0_wr && (timer0 == 8'hFF); // [R3]

  // ====================
  // timer zero counter
  always_ff @(posedge clk) begin
    if (!rstn || wdt_rst) begin
      timer0 <= `ISW_RST_TIMER0;
    end else if (t0_wr) begin
      timer0 <= reg_wdata;
    end else if (t0_inc) begin
      timer0 <= timer0 + 8'h01;
    end
  end

  // ====================
  // option register
  always_ff @(posedge clk) begin
    if (!rstn || wdt_rst) begin
      option <= `ISW_RST_OPTION;
    end else if (opt_wr) begin
      option <= reg_wdata;
    end
  end

  // ====================
  // interrupt control; hardware sets win over a bus clear
  always_ff @(posedge clk) begin
    if (!rstn || wdt_rst) begin
      irqctl <= `ISW_RST_IRQCTL;
    end else begin
      // flags stay until software writes them low
      if (irq_wr) begin
        irqctl <= reg_wdata; // [R25]
      end
      // flags set whatever the enables say
      if (ext_evt) begin
        irqctl[`ISW_IRQ_EXT_FLAG] <= 1'b1; // [R1] [R22]
      end
      if (t0_ovf) begin
        irqctl[`ISW_IRQ_T0_FLAG] <= 1'b1; // [R3] [R22]
      end
      if (port_evt) begin
        irqctl[`ISW_IRQ_PORT_CHG_FLAG] <= 1'b1; // [R4] [R22]
      end
      if (take_irq) begin
        irqctl[`ISW_IRQ_GLOBAL_EN] <= 1'b0; // [R23]
      end else if (return_from_irq_instr_evt) begin
        irqctl[`ISW_IRQ_GLOBAL_EN] <= 1'b1; // [R24]
      end
    end
  end

  // ====================
  // status flags
  always_ff @(posedge clk) begin
    if (!rstn) begin
      // power-up and reset pin
      to_n <= 1'b1;
      pd_n <= 1'b1; // [R17]
    end else if (wdt_timeout) begin
      to_n <= 1'b0; // [R9]
      if (run) begin
        pd_n <= 1'b1;
      end
    end else if (sleep_taken) begin
      to_n <= 1'b1; // [R14]
      pd_n <= 1'b0; // [R14] [R17]
    end
  end

  // ====================
  // run state
  always_comb begin
    next_state = state;
    unique case (state)
      isw_st_run: begin
        if (sleep_taken && !wdt_rst) begin
          next_state = isw_st_sleep;
        end
      end
      isw_st_sleep: begin
        // reset pin acts through rstn, the others wake
        if (wake_req || wdt_timeout) begin
          next_state = isw_st_run; // [R8] [R16]
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= isw_st_run;
      osc_driver_off <= 1'b0;
    end else begin
      state <= next_state;
      osc_driver_off <= (next_state == isw_st_sleep); // [R14]
    end
  end

  // ====================
  // device reset pulse on awake time-out
  always_ff @(posedge clk) begin
    if (!rstn) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= wdt_rst; // [R7]
    end
  end

  // ====================
  // pin drive latch, frozen while asleep
  always_ff @(posedge clk) begin
    if (!rstn) begin
      second_port_out <= 8'h00;
      second_port_oe <= 8'h00;
    end else if (next_state == isw_st_run && run) begin
      second_port_out <= port_drive_d; // [R15]
      second_port_oe <= port_oe_d;
    end
  end

  // ====================
  // vectoring: only the return address is saved
  always_ff @(posedge clk) begin
    if (!rstn) begin
      stack_push <= 1'b0;
      stack_push_data <= 13'h0000;
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      pc_load_addr <= `ISW_IRQ_VECTOR;
    end else begin
      stack_push <= take_irq; // [R5] [R23]
      pc_load <= take_irq;
      stack_pop <= return_from_irq_instr_evt && !take_irq; // [R24]
      if (take_irq) begin
        stack_push_data <= core_pc;
      end
      pc_load_addr <= `ISW_IRQ_VECTOR;
    end
  end

  // ====================
  // register read port, data one cycle after strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `ISW_ADDR_TIMER0: reg_rdata <= timer0;
        `ISW_ADDR_STATUS: reg_rdata <= {3'h0, to_n, pd_n, 3'h0};
        `ISW_ADDR_IRQCTL: reg_rdata <= irqctl;
        `ISW_ADDR_OPTION, `ISW_ADDR_OPTION_HI: reg_rdata <= option;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ====================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_sleep_entered;
    !pd_n && to_n && osc_driver_off;
  endsequence
  sequence s_reset_pulse;
    device_reset ##1 !device_reset;
  endsequence

  property p_ext_flag;
    ext_evt && !wdt_rst |=> irqctl[`ISW_IRQ_EXT_FLAG];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("ext edge lost"); // [R1]

  property p_t0_wrap;
    t0_ovf && !wdt_rst |=> irqctl[`ISW_IRQ_T0_FLAG] && timer0 == 8'h00;
  endproperty
  a_t0_wrap: assert property (p_t0_wrap) else $error("timer wrap flag missing"); // [R3]

  property p_port_flag;
    port_evt && !wdt_rst |=> irqctl[`ISW_IRQ_PORT_CHG_FLAG];
  endproperty
  a_port_flag: assert property (p_port_flag) else $error("port change lost"); // [R4]

  property p_sleep_entry;
    sleep_taken && !wdt_timeout |=> s_sleep_entered;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong"); // [R14]

  property p_timeout_flag;
    wdt_timeout |=> !to_n;
  endproperty
  a_timeout_flag: assert property (p_timeout_flag) else $error("time-out flag not cleared"); // [R9]

  property p_wdt_reset;
    wdt_rst |=> s_reset_pulse;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("no watchdog reset"); // [R7]

  property p_wdt_wake;
    wdt_timeout && !run |=> !osc_driver_off && !device_reset;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong"); // [R8]

  property p_wdt_off;
    !wdt_en |-> ##1 (wdt_base == 16'h0000) && !device_reset;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog ran"); // [R10]

  property p_irq_entry;
    take_irq |=> stack_push && pc_load && pc_load_addr == 13'h0004 && !irqctl[`ISW_IRQ_GLOBAL_EN];
  endproperty
  a_irq_entry: assert property (p_irq_entry) else $error("interrupt entry wrong"); // [R23]

  property p_return_from_irq_instr;
    return_from_irq_instr_evt && !take_irq && !wdt_rst |=> irqctl[`ISW_IRQ_GLOBAL_EN] && stack_pop;
  endproperty
  a_return_from_irq_instr: assert property (p_return_from_irq_instr) else $error("return did not re-enable"); // [R24]

  property p_pins_hold;
    !run && $past(!run) |-> $stable(second_port_out) && $stable(second_port_oe);
  endproperty
  a_pins_hold: assert property (p_pins_hold) else $error("pins moved asleep"); // [R15]

  property p_wdt_clear;
    wdt_clr_evt |=> wdt_base == 16'h0000;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not cleared"); // [R12]
endmodule
`default_nettype wire

// ==== isw_pkg.sv ====
// types shared by the interrupt, sleep and watchdog block
// assumes nothing beyond a SystemVerilog compiler
package isw_pkg;
  // core run state
  typedef enum logic [0:0] {
    isw_st_run = 1'b0,
    isw_st_sleep = 1'b1
  } isw_state_e;
  typedef logic [7:0] isw_byte_t;
  typedef logic [12:0] isw_pc_t;
endpackage

// ==== isw_scaler.sv ====
// shared scaler for timer zero or watchdog
// assumes tick_in and clear are one-cycle pulses on clk
`timescale 1ns/1ps
`default_nettype none
module isw_scaler (
  input wire logic clk,
  input wire logic rstn,
  input wire logic tick_in,
  input wire logic clear,
  input wire logic assign_wdt,
  input wire logic [2:0] ratio,
  output logic tick_out
);
  // ====================
  // terminal count
  // watchdog divides 1..128, timer divides 2..256
  function automatic logic [7:0] isw_limit(input logic wdt, input logic [2:0] r);
    logic [8:0] span;
    span = wdt ? (9'h001 << r) : (9'h002 << r);
    return span[7:0] - 8'h01;
  endfunction

  logic [7:0] count; // scaler count
  logic [7:0] limit; // selected terminal value
  assign limit = isw_limit(assign_wdt, ratio);

  // ====================
  // count and output pulse
  always_ff @(posedge clk) begin
    if (!rstn || clear) begin
      count <= 8'h00;
      tick_out <= 1'b0;
    end else if (tick_in) begin
      // wrap at terminal count
      if (count == limit) begin
        count <= 8'h00;
        tick_out <= 1'b1;
      end else begin
        count <= count + 8'h01;
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== isw_wdt_osc_model.sv ====
// free-running watchdog oscillator standing beside the block
// assumes a tb clock of 25 ns; phase and rate unrelated to it
`timescale 1ns/1ps
`default_nettype none
// ====================
// oscillator
module isw_wdt_osc_model (
  output var logic osc
);
  // own rc oscillator, never stopped, also while asleep
  initial osc = 1'b0;
  always #47.3 osc = ~osc; // slow enough for a two-stage sync
endmodule
`default_nettype wire

// ==== tb.sv ====
// register-level regression of the interrupt, sleep and watchdog block
// assumes the design files and the oscillator model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "isw_defs.svh"
// ====================
// bench top
module tb;
  import isw_pkg::*;
  logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, timer_zero_pin = 0;
  logic [8:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, config_word = 0, second_port_in = 0, port_drive_d = 0, port_oe_d = 0;
  logic periph_irq_req = 0, periph_wake_req = 0, wdt_osc_in;
  logic sleep_instr = 0, watchdog_clear_instr = 0, return_from_irq_instr = 0, instr_boundary = 0;
  logic [12:0] core_pc = 0, stack_push_data, pc_load_addr;
  logic [7:0] reg_rdata, second_port_out, second_port_oe;
  logic osc_driver_off, device_reset, stack_push, stack_pop, pc_load;
  int mismatches = 0, check_count = 0, cycles = 0, resets = 0, takes = 0;
  isw_byte_t v;
  isw_wdt_osc_model osc_model (.osc(wdt_osc_in));
  isw_irq_sleep_wdt #(.WDT_BASE_TICKS(4)) dut (.clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .config_word, .wdt_osc_in, .timer_zero_pin, .second_port_in, .port_drive_d,
    .port_oe_d, .second_port_out, .second_port_oe, .periph_irq_req, .periph_wake_req, .sleep_instr,
    .watchdog_clear_instr, .return_from_irq_instr, .instr_boundary, .core_pc, .osc_driver_off,
    .device_reset, .stack_push, .stack_push_data, .stack_pop, .pc_load, .pc_load_addr);
  // ====================
  // clock, watchdog reset and take counters, hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (device_reset === 1'b1) resets++;
    if (pc_load === 1'b1) takes++;
    if (cycles == 30000) begin
      mismatches++;
      finish_test;
    end
  end
  // ====================
  // tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string name, input logic [12:0] seen, input logic [12:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read; data stand in the cycle after the strobe
  task automatic rdchk(input string name, input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(name, 13'(reg_rdata), 13'(exp));
  endtask
  // core instruction pulses {boundary, return, clear, sleep}
  task automatic ins(input logic [3:0] s);
    @(posedge clk);
    {instr_boundary, return_from_irq_instr, watchdog_clear_instr, sleep_instr} <= s;
    @(posedge clk);
    {instr_boundary, return_from_irq_instr, watchdog_clear_instr, sleep_instr} <= 4'h0;
    #1;
  endtask
  // pin change, then room for sync and edge detect
  task automatic pin(input logic [7:0] p);
    @(posedge clk);
    second_port_in <= p;
    repeat (5) @(posedge clk);
  endtask
  task automatic wake_wait(input int n);
    for (int i = 0; i < n && osc_driver_off !== 1'b0; i++) @(posedge clk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // ====================
  // main sequence
  initial begin
    do_reset;
    rdchk("option", 9'h081, 8'hFF);
    rdchk("irqctl", 9'h00B, 8'h00);
    rdchk("timer0", 9'h001, 8'h00);
    rdchk("status", 9'h003, 8'h18);
    rdchk("unmapped", 9'h0F0, 8'h00);
    wr(9'h003, 8'h00);
    rdchk("status ro", 9'h003, 8'h18);
    // rising select, pin clock for timer, scaler on watchdog
    wr(9'h181, 8'h68);
    rdchk("option alias", 9'h081, 8'h68);
    pin(8'h01);
    rdchk("ext rise", 9'h00B, 8'h02);
    wr(9'h00B, 8'h00);
    pin(8'h00);
    rdchk("fall ignored", 9'h00B, 8'h00);
    // falling select
    wr(9'h081, 8'h28);
    pin(8'h01);
    rdchk("rise ignored", 9'h00B, 8'h00);
    pin(8'h00);
    rdchk("ext fall", 9'h00B, 8'h02);
    pin(8'h10);
    rdchk("port change", 9'h00B, 8'h03);
    pin(8'h11);
    rdchk("flags sticky", 9'h00B, 8'h03);
    wr(9'h00B, 8'h01);
    rdchk("flag write 0", 9'h00B, 8'h01);
    // timer wrap FF to 00 on two pin edges
    wr(9'h00B, 8'h00);
    wr(9'h001, 8'hFE);
    repeat (2) begin
      timer_zero_pin <= 1'b1;
      repeat (4) @(posedge clk);
      timer_zero_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    rdchk("timer wrap", 9'h00B, 8'h04);
    rdchk("timer zero", 9'h001, 8'h00);
    // interrupt take and return
    wr(9'h00B, 8'hA4);
    core_pc <= 13'h0123;
    ins(4'h8);
    chk("push", 13'(stack_push), 13'h1);
    chk("pc load", 13'(pc_load), 13'h1);
    chk("push data", stack_push_data, 13'h0123);
    chk("vector", pc_load_addr, `ISW_IRQ_VECTOR);
    rdchk("gie cleared", 9'h00B, 8'h24);
    ins(4'h8);
    chk("no retake", 13'(stack_push), 13'h0);
    ins(4'h4);
    chk("pop", 13'(stack_pop), 13'h1);
    rdchk("gie set", 9'h00B, 8'hA4);
    // sleep refused while a wake source is pending
    wr(9'h00B, 8'h12);
    ins(4'h1);
    chk("sleep nop", 13'(osc_driver_off), 13'h0);
    rdchk("pd kept", 9'h003, 8'h18);
    // sleep, pins frozen, no watchdog, ext wake with gie clear
    wr(9'h00B, 8'h10);
    port_drive_d <= 8'hA5;
    port_oe_d <= 8'h0F;
    ins(4'h1);
    chk("asleep", 13'(osc_driver_off), 13'h1);
    rdchk("pd cleared", 9'h003, 8'h10);
    port_drive_d <= 8'h5A;
    port_oe_d <= 8'hF0;
    repeat (100) @(posedge clk);
    #1;
    chk("pins held", 13'(second_port_out), 13'h0A5);
    chk("oe held", 13'(second_port_oe), 13'h00F);
    chk("no watchdog", 13'(osc_driver_off), 13'h1);
    v = 8'(takes);
    pin(8'h10);
    wake_wait(10);
    chk("ext wake", 13'(osc_driver_off), 13'h0);
    repeat (3) @(posedge clk);
    chk("in line", 13'(takes), 13'(v));
    chk("pins follow", 13'(second_port_out), 13'h05A);
    // peripheral wake needs a sleep-capable source
    wr(9'h00B, 8'h40);
    ins(4'h1);
    periph_irq_req <= 1'b1;
    repeat (10) @(posedge clk);
    chk("no periph wake", 13'(osc_driver_off), 13'h1);
    periph_wake_req <= 1'b1;
    wake_wait(10);
    chk("periph wake", 13'(osc_driver_off), 13'h0);
    periph_irq_req <= 1'b0;
    periph_wake_req <= 1'b0;
    wr(9'h00B, 8'h00);
    // watchdog kept off by clears, then awake time-out
    config_word <= 8'h04;
    wr(9'h081, 8'h68);
    repeat (40) begin
      ins(4'h2);
      repeat (3) @(posedge clk);
    end
    chk("cleared watchdog", 13'(resets), 13'h0);
    rdchk("assign kept", 9'h081, 8'h68);
    for (int i = 0; i < 200 && resets == 0; i++) @(posedge clk);
    chk("wdt reset", 13'(resets), 13'h1);
    rdchk("to cleared", 9'h003, 8'h08);
    rdchk("option reset", 9'h081, 8'hFF);
    // ratio 1:8 time-out while asleep wakes
    wr(9'h081, 8'h6B);
    ins(4'h1);
    repeat (60) @(posedge clk);
    chk("ratio wait", 13'(osc_driver_off), 13'h1);
    wake_wait(400);
    chk("wdt wake", 13'(osc_driver_off), 13'h0);
    chk("no reset", 13'(resets), 13'h1);
    rdchk("wake flags", 9'h003, 8'h00);
    // config bit clear turns the watchdog off
    config_word <= 8'h00;
    repeat (3) @(posedge clk);
    // timer on the instruction clock through the scaler at 1:2
    wr(9'h081, 8'h00);
    wr(9'h001, 8'hFE);
    wr(9'h00B, 8'h00);
    repeat (8) @(posedge clk);
    rdchk("scaled wrap", 9'h00B, 8'h04);
    rdchk("scaled count", 9'h001, 8'h04);
    ins(4'h1);
    do_reset;
    chk("pin reset", 13'(osc_driver_off), 13'h0);
    rdchk("reset flags", 9'h003, 8'h18);
    finish_test;
  end
endmodule
`default_nettype wire
